// *** rtl/scsr_pkg.sv ***
package scsr_pkg;
  // Register offsets
  localparam logic [7:0] CAPTURE_CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] CHIP_POWER_CLOCK_CONTROL_OFFSET = 8'h09;
  localparam logic [7:0] OUTPUT_PIN_CONTROL_OFFSET = 8'h0a;
  localparam logic [7:0] CAPTURE_STATUS_SHADOW_OFFSET = 8'h0b;
  localparam logic [7:0] AMPLIFIER_GAIN_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_CONTROL_OFFSET = 8'h0d;
  // Power/clock control fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int IDLE_BIT = 5;
  localparam int FINGER_DETECT_ENABLE_BIT = 3;
  localparam int SCAN_AUTO_ADVANCE_BIT = 2;
  localparam int LOGIC_CLOCK_SOURCE_SELECT_BIT = 1;
  localparam int CHIP_ENABLE_BIT = 0;
  localparam logic [4:0] CONTROL_LOW_RESET = 5'h00;
  // Output pin control fields
  localparam int PIN_B_RATE_HI = 7;
  localparam int PIN_B_RATE_LO = 5;
  localparam int PIN_A_RATE_HI = 4;
  localparam int PIN_A_RATE_LO = 2;
  localparam int PIN_B_LEVEL_BIT = 1;
  localparam int PIN_A_LEVEL_BIT = 0;
  localparam logic [7:0] OUTPUT_PIN_RESET = 8'h00;
  localparam logic [2:0] RATE_STATIC = 3'h0;
  localparam logic [2:0] RATE_DIV24 = 3'h1;
  localparam logic [2:0] RATE_DIV21 = 3'h4;
  localparam int DIVIDER_WIDTH = 24;
  // Capture control fields
  localparam int ANALOG_INPUT_SELECT_BIT = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  // Interrupt control enable bit for finger detect
  localparam int FINGER_IRQ_ENABLE_BIT = 0;
  // Interface modes taken from the strap pins
  typedef enum logic [1:0] {
    SCSR_MODE_CPU = 2'b00,
    SCSR_MODE_SPI = 2'b01,
    SCSR_MODE_USB = 2'b10,
    SCSR_MODE_RSV = 2'b11
  } scsr_mode_type;
  // Next conversion after a result read
  localparam int CONVERT_CYCLES = 6;
  localparam int ROW_LAST = 299;
  localparam int COL_LAST = 255;
endpackage : scsr_pkg

// *** rtl/scsr_pin_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface scsr_pin_if;
  logic [2:0] rate;
  logic       level;
  logic       pinOut;
  modport ctrl (output rate, output level, input pinOut);
  modport gen  (input rate, input level, output pinOut);
endinterface : scsr_pin_if
`default_nettype wire

// *** rtl/scsr_pin_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module scsr_pin_gen #(
  parameter int DIV_WIDTH = scsr_pkg::DIVIDER_WIDTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Shared divider
  input wire logic [DIV_WIDTH-1:0] divCount,
  // Pin control
  scsr_pin_if.gen                  pin
);
  logic [4:0] tapIndex;
  logic       waveBit;
  logic       nextPin;

  // Code 1 taps the top bit (divide by 2^24), code 4 divides by 2^21
  assign tapIndex = 5'(DIV_WIDTH) - 5'd1 - {2'b00, pin.rate} + 5'd1;
  assign waveBit  = divCount[tapIndex];
  assign nextPin  = (pin.rate == scsr_pkg::RATE_STATIC) ? pin.level :
                    (pin.rate <= scsr_pkg::RATE_DIV21) ? waveBit : 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin.pinOut <= 1'b0;
    end else begin
      pin.pinOut <= nextPin;
    end
  end
endmodule : scsr_pin_gen
`default_nettype wire

// *** rtl/scsr_regs.sv ***
// How it works
// - Reset loads straps, idle flag, zeros
// - Mode bits track straps, ignore writes
// - Idle flag reads converter state only
// - Finger detect enable raises interrupt
// - Detection works while chip disabled
// - Auto-advance off keeps addresses fixed
// - Auto-advance steps column, then row
// - Clock select, ignored in USB mode
// - Enable bit powers chip and converter
// - Pin one rate: static or divide
// - Pin zero rate uses same encoding
// - Static pin one follows level bit
// - Static pin zero follows level bit
// - Status shadows capture control, top zero
// - Status bit three follows input select
// - Capture status clears after final byte
// - Gain upper bits read zero
// - Gain code drives amplifier setting
// - Disabled interrupt still sets pending
// - Auto-advance result read starts conversion, six cycles
`timescale 1ns/1ps
`default_nettype none
module scsr_regs (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWriteData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output var  logic [7:0] regReadData,
  // Strap and sensor inputs
  input  wire logic [1:0] modeStrap,
  input  wire logic       fingerSense,
  // Converter result
  input  wire logic [7:0] convResult,
  // Chip controls
  output var  logic       chipEnable,
  output var  logic       logicClockSourceSelect,
  output var  logic       convStart,
  output var  logic       convIdle,
  output var  logic [8:0] rowAddr,
  output var  logic [7:0] colAddr,
  output var  logic [3:0] ampGainCode,
  output var  logic       fingerPending,
  output var  logic       irqOutput,
  output var  logic       usbIrqRequest,
  // General output pins
  output var  logic       outPinA,
  output var  logic       outPinB
);
  logic [1:0] modeSync1, modeSync2, modeSync3, modeStable;
  logic [2:0] fingerSync;
  logic       fingerStable;
  logic       strapLoaded;
  logic [4:0] ctrlLow;
  logic [7:0] pinCtrl;
  logic [3:0] gain;
  logic [3:0] statusShadow;
  logic [7:0] irqCtrl;
  logic       fingerPrev;
  logic       pendingBit;
  logic [2:0] convCount;
  logic       readPrev;
  logic [8:0] row;
  logic [7:0] col;
  logic [23:0] divCount;
  logic       irqReg, usbReg, enReg, clkSelReg, startReg;
  logic [7:0] readData;

  wire isUsb        = modeStable == scsr_pkg::SCSR_MODE_USB;
  wire wrCapture    = regWrite && (regAddr == scsr_pkg::CAPTURE_CONTROL_OFFSET);
  wire wrCtrl       = regWrite && (regAddr == scsr_pkg::CHIP_POWER_CLOCK_CONTROL_OFFSET);
  wire wrPin        = regWrite && (regAddr == scsr_pkg::OUTPUT_PIN_CONTROL_OFFSET);
  wire wrGain       = regWrite && (regAddr == scsr_pkg::AMPLIFIER_GAIN_OFFSET);
  wire wrIrq        = regWrite && (regAddr == scsr_pkg::IRQ_CONTROL_OFFSET);
  wire rdCapture    = regRead && (regAddr == scsr_pkg::CAPTURE_CONTROL_OFFSET);
  wire readRise     = rdCapture && !readPrev;
  wire autoAdvance  = ctrlLow[scsr_pkg::SCAN_AUTO_ADVANCE_BIT];
  wire enabled      = ctrlLow[scsr_pkg::CHIP_ENABLE_BIT];
  wire idle         = (convCount == 3'd0);
  wire lastCol      = (col == 8'(scsr_pkg::COL_LAST));
  wire lastRow      = (row == 9'(scsr_pkg::ROW_LAST));
  wire captureBusy  = |statusShadow[2:0];
  wire lastByteRead = readRise && captureBusy && lastCol &&
                      (statusShadow[0] || lastRow);
  wire fingerEvent  = ctrlLow[scsr_pkg::FINGER_DETECT_ENABLE_BIT] && fingerStable && !fingerPrev;
  wire irqEnabled   = irqCtrl[scsr_pkg::FINGER_IRQ_ENABLE_BIT];
  wire nextIrq      = pendingBit && irqEnabled && !isUsb;
  wire nextUsbIrq   = fingerEvent && irqEnabled && isUsb;

  assign readData =
    (regAddr == scsr_pkg::CAPTURE_CONTROL_OFFSET) ? convResult :
    (regAddr == scsr_pkg::CHIP_POWER_CLOCK_CONTROL_OFFSET) ?
      {modeStable, idle, ctrlLow} :
    (regAddr == scsr_pkg::OUTPUT_PIN_CONTROL_OFFSET) ? pinCtrl :
    (regAddr == scsr_pkg::CAPTURE_STATUS_SHADOW_OFFSET) ? {4'h0, statusShadow} :
    (regAddr == scsr_pkg::AMPLIFIER_GAIN_OFFSET) ? {4'h0, gain} :
    (regAddr == scsr_pkg::IRQ_CONTROL_OFFSET) ? irqCtrl : 8'h00;

  // Strap and finger inputs through three flops
  always_ff @(posedge core_clk) begin
    modeSync1  <= modeStrap;
    modeSync2  <= modeSync1;
    modeSync3  <= modeSync2;
    fingerSync <= {fingerSync[1:0], fingerSense};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      modeStable   <= 2'b00;
      fingerStable <= 1'b0;
      strapLoaded  <= 1'b0;
    end else begin
      strapLoaded <= 1'b1;
      if (modeSync2 == modeSync3 || !strapLoaded) begin
        modeStable <= modeSync3;
      end
      if (fingerSync[1] == fingerSync[2]) begin
        fingerStable <= fingerSync[2];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlLow <= scsr_pkg::CONTROL_LOW_RESET;
      pinCtrl <= scsr_pkg::OUTPUT_PIN_RESET;
      gain    <= scsr_pkg::GAIN_RESET;
      irqCtrl <= 8'h00;
    end else begin
      if (wrCtrl) begin
        ctrlLow <= {1'b0, regWriteData[3:0]};
      end
      if (wrPin) begin
        pinCtrl <= regWriteData;
      end
      if (wrGain) begin
        gain <= regWriteData[3:0];
      end
      if (wrIrq) begin
        irqCtrl <= regWriteData;
      end
    end
  end

  // capture bits set, clear on last byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      statusShadow <= scsr_pkg::STATUS_RESET;
    end else if (wrCapture && |regWriteData[2:0]) begin
      statusShadow <= regWriteData[3:0];
    end else if (wrCapture) begin
      statusShadow[3] <= regWriteData[scsr_pkg::ANALOG_INPUT_SELECT_BIT];
    end else if (lastByteRead) begin
      statusShadow[2:0] <= 3'b000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      convCount <= 3'd0;
      readPrev  <= 1'b0;
      startReg  <= 1'b0;
    end else begin
      readPrev <= rdCapture;
      startReg <= 1'b0;
      if (!enabled) begin
        convCount <= 3'd0;
      end else if ((readRise && autoAdvance && captureBusy && !lastByteRead) ||
                   (wrCapture && |regWriteData[2:0])) begin
        convCount <= 3'(scsr_pkg::CONVERT_CYCLES);
        startReg  <= 1'b1;
      end else if (!idle) begin
        convCount <= convCount - 3'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      row <= 9'd0;
      col <= 8'd0;
    end else if (wrCapture && regWriteData[1]) begin
      row <= 9'd0;
      col <= 8'd0;
    end else if (wrCapture && regWriteData[0]) begin
      col <= 8'd0;
    end else if (readRise && autoAdvance && captureBusy) begin
      col <= col + 8'd1;
      if (lastCol) begin
        row <= row + 9'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fingerPrev <= 1'b0;
      pendingBit <= 1'b0;
    end else begin
      fingerPrev <= fingerStable;
      if (fingerEvent) begin
        pendingBit <= 1'b1;
      end else if (wrIrq && regWriteData[7]) begin
        pendingBit <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqReg      <= 1'b0;
      usbReg      <= 1'b0;
      enReg       <= 1'b0;
      clkSelReg   <= 1'b0;
      regReadData <= 8'h00;
      divCount    <= 24'h000000;
    end else begin
      irqReg      <= nextIrq;
      usbReg      <= nextUsbIrq;
      enReg       <= enabled;
      clkSelReg   <= ctrlLow[scsr_pkg::LOGIC_CLOCK_SOURCE_SELECT_BIT] && !isUsb;
      regReadData <= readData;
      divCount    <= divCount + 24'h000001;
    end
  end

  assign chipEnable             = enReg;
  assign logicClockSourceSelect = clkSelReg;
  assign convStart              = startReg;
  assign convIdle               = idle;
  assign rowAddr                = row;
  assign colAddr                = col;
  assign ampGainCode            = gain;
  assign fingerPending          = pendingBit;
  assign irqOutput              = irqReg;
  assign usbIrqRequest          = usbReg;

  scsr_pin_if pinA ();
  scsr_pin_if pinB ();
  assign pinA.rate  = pinCtrl[scsr_pkg::PIN_A_RATE_HI:scsr_pkg::PIN_A_RATE_LO];
  assign pinA.level = pinCtrl[scsr_pkg::PIN_A_LEVEL_BIT];
  assign pinB.rate  = pinCtrl[scsr_pkg::PIN_B_RATE_HI:scsr_pkg::PIN_B_RATE_LO];
  assign pinB.level = pinCtrl[scsr_pkg::PIN_B_LEVEL_BIT];

  scsr_pin_gen genA (.core_clk(core_clk), .rst(rst), .divCount(divCount), .pin(pinA.gen));
  scsr_pin_gen genB (.core_clk(core_clk), .rst(rst), .divCount(divCount), .pin(pinB.gen));

  assign outPinA = pinA.pinOut;
  assign outPinB = pinB.pinOut;
endmodule : scsr_regs
`default_nettype wire

// *** bench/scsr_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module scsr_regs_monitor (
  // Clock, reset and register port
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic       regWrite,
  input wire logic [7:0] regReadData,
  // Device side
  input wire logic       chipEnable,
  input wire logic       convStart,
  input wire logic       convIdle,
  input wire logic [3:0] ampGainCode,
  input wire logic       fingerPending,
  input wire logic       irqOutput,
  input wire logic       outPinA,
  input wire logic       outPinB
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_all_clear: assert property ($fell(rst) |-> !chipEnable && ampGainCode == 4'h0 && !outPinA && !outPinB)
    else $error("outputs not clear after reset");
  a_idle_flag_read: assert property (!$past(rst) && !$past(regWrite) && $past(regAddr) == 8'h09
    |-> regReadData[5:4] == {$past(convIdle), 1'b0} && regReadData[0] == chipEnable)
    else $error("control read value wrong");
  // Enable output lags the register by one flop
  a_enable_write: assert property (regWrite && regAddr == 8'h09 |-> ##2 chipEnable == $past(regWriteData[0], 2))
    else $error("enable bit not taken");
  a_gain_write: assert property (regWrite && regAddr == 8'h0c |=> ampGainCode == $past(regWriteData[3:0]))
    else $error("gain code not taken");
  a_gain_upper_zero: assert property (!$past(rst) && $past(regAddr) == 8'h0c |-> regReadData[7:4] == 4'h0)
    else $error("gain upper bits not zero");
  a_status_upper_zero: assert property (!$past(rst) && $past(regAddr) == 8'h0b |-> regReadData[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_pin_b_static: assert property (regWrite && regAddr == 8'h0a && regWriteData[7:5] == 3'h0
    |-> ##2 outPinB == $past(regWriteData[1], 2))
    else $error("pin b not following level");
  a_pin_a_static: assert property (regWrite && regAddr == 8'h0a && regWriteData[4:2] == 3'h0
    |-> ##2 outPinA == $past(regWriteData[0], 2))
    else $error("pin a not following level");
  a_conv_goes_busy: assert property (convStart |-> ##[1:2] !convIdle)
    else $error("conversion did not start");
  a_conv_ends_bound: assert property ($fell(convIdle) |-> ##[1:7] convIdle)
    else $error("conversion too long");
  a_irq_needs_pending: assert property (irqOutput |-> $past(fingerPending))
    else $error("interrupt without pending");
  cover property (convStart);
  cover property (irqOutput);
  cover property (fingerPending && !irqOutput);
endmodule : scsr_regs_monitor
`default_nettype wire

// *** bench/scsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module scsr_host (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWriteData,
  output var  logic       regWrite,
  output var  logic       regRead,
  input  wire logic [7:0] regReadData
);
  initial begin
    regAddr = 8'h00;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    // Stale data must not look valid
    regWriteData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    #1 d = regReadData;
    @(posedge core_clk);
    regRead <= 1'b0;
  endtask : rd
endmodule : scsr_host
`default_nettype wire

// *** bench/test_sensor_control_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sensor_control_status_regs;
  logic       core_clk    = 1'b0;
  logic       rst         = 1'b1;
  logic [1:0] modeStrap   = 2'b01;
  logic       fingerSense = 1'b0;
  logic [7:0] convResult  = 8'h00;
  logic [7:0] regAddr, regWriteData, regReadData, d, g, colAddr;
  logic [3:0] ampGainCode;
  logic       regWrite, regRead, chipEnable, clkSel, irqOutput, fingerPending, outPinA, outPinB;
  int         errors      = 0;
  int         n_compared  = 0;
  always #25 core_clk = ~core_clk;
  scsr_host host_u (.core_clk(core_clk), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData));
  scsr_regs dut_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .modeStrap(modeStrap),
    .fingerSense(fingerSense), .convResult(convResult), .chipEnable(chipEnable), .logicClockSourceSelect(clkSel),
    .convStart(), .convIdle(), .rowAddr(), .colAddr(colAddr), .ampGainCode(ampGainCode),
    .fingerPending(fingerPending), .irqOutput(irqOutput), .usbIrqRequest(), .outPinA(outPinA), .outPinB(outPinB));
  function automatic logic [7:0] ctrlExp(input logic [1:0] m, input logic [7:0] w);
    return {m, 2'b10, w[3:0]};
  endfunction : ctrlExp
  function automatic logic pinExp(input logic [2:0] r, input logic lvl);
    return (r == 3'h0) ? lvl : 1'b0;
  endfunction : pinExp
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic finger_pulse();
    @(posedge core_clk) fingerSense <= 1'b1;
    tick(10);
    @(posedge core_clk) fingerSense <= 1'b0;
    tick(6);
  endtask : finger_pulse
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h563cfb89));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    tick(5);
    host_u.rd(8'h09, d);
    check(d, ctrlExp(2'b01, 8'h00));
    host_u.wr(8'h09, 8'hff);
    host_u.rd(8'h09, d);
    check(d, ctrlExp(2'b01, 8'hff));
    check(8'(clkSel), 8'h01);
    @(posedge core_clk) modeStrap <= 2'b10;
    tick(6);
    host_u.rd(8'h09, d);
    check(d, ctrlExp(2'b10, 8'hff));
    @(posedge core_clk) modeStrap <= 2'b01;
    host_u.wr(8'h0b, 8'hff);
    host_u.rd(8'h0b, d);
    check(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      convResult <= 8'($urandom);
      host_u.wr(8'h0c, d);
      host_u.rd(8'h0c, g);
      check(g, {4'h0, d[3:0]});
      check(8'(ampGainCode), 8'(d[3:0]));
    end
    for (int i = 0; i < 16; i++) begin
      d = {i[2:0], ~i[2:0], i[3], ~i[3]};
      host_u.wr(8'h0a, d);
      host_u.rd(8'h0a, g);
      check(g, d);
      if (d[7:5] == 3'h0 || d[7:5] > 3'h4) check(8'(outPinB), 8'(pinExp(d[7:5], d[1])));
      if (d[4:2] == 3'h0 || d[4:2] > 3'h4) check(8'(outPinA), 8'(pinExp(d[4:2], d[0])));
    end
    host_u.wr(8'h09, 8'h0b);
    host_u.wr(8'h08, 8'h09);
    host_u.rd(8'h0b, g);
    check(g, 8'h09);
    host_u.rd(8'h08, g);
    tick(8);
    check(colAddr, 8'h00);
    host_u.wr(8'h08, 8'h01);
    host_u.rd(8'h0b, g);
    check(g, 8'h01);
    host_u.wr(8'h09, 8'h0f);
    for (int i = 1; i <= 256; i++) begin
      convResult <= 8'($urandom);
      host_u.rd(8'h08, g);
      tick(6);
      if (i < 256) check(colAddr, 8'(i));
    end
    host_u.rd(8'h0b, g);
    check(g, 8'h00);
    host_u.wr(8'h09, 8'h08);
    host_u.wr(8'h0d, 8'h01);
    finger_pulse();
    check(8'(irqOutput), 8'h01);
    host_u.wr(8'h0d, 8'h80);
    finger_pulse();
    check({6'h00, fingerPending, irqOutput}, 8'h02);
    tally_and_finish();
  end
endmodule : test_sensor_control_status_regs
bind scsr_regs scsr_regs_monitor mon_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regReadData(regReadData), .chipEnable(chipEnable),
  .convStart(convStart), .convIdle(convIdle), .ampGainCode(ampGainCode), .fingerPending(fingerPending),
  .irqOutput(irqOutput), .outPinA(outPinA), .outPinB(outPinB));
`default_nettype wire
